// >>> hw/cvl_registers.sv
// Charge voltage limit and minimum system voltage setting registers.
// Assumes an I2C engine on CLK delivering complete 16-bit writes and reads.
//
// Functional notes
// R1: Charge voltage is a 12-bit code, LSB at low-byte bit 3, 8 mV.
// R2: Upper charge code bits sit in high-byte bits 6..0, MSB 16384 mV.
// R3: Reserved top high-byte bits set to one make the write invalid.
// R4: Reserved low-byte bits are ignored and never stored.
// R5: Minimum system voltage is written as one 16-bit two-byte command.
// R6: Minimum system voltage spans 1.024 V to 16.128 V in 256 mV steps.
// R7: Out-of-range minimum system writes are dropped; old value kept.
// R8: Reset minimum system voltage follows cell count strap.
// R9: Minimum system code is 6 bits in high-byte bits 5..0, 256 mV LSB.
// R10: Minimum system code MSB is 8192 mV; reserved bits 7..6 read zero.
// R11: Charge voltage writes outside 1.024 V to 19.200 V, other than zero, are ignored.
// R12: Reset charge voltage is 4200 mV times strapped cell count.
// R13: Writing zero to charge voltage restores default, clears charge current.
// R14: Host writes charge voltage before charge current for non-4.2 V cells.
// R15: Reads return the active value: last accepted write or default.
`timescale 1ns/1ps
module cvl_registers (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [1:0] CELL_COUNT_STRAP_PIN,
	input wire logic WR_VALID,
	input wire logic [7:0] WR_OFFSET,
	input wire logic [15:0] WR_DATA,
	input wire logic [7:0] RD_OFFSET,
	output logic [15:0] RD_DATA,
	output logic WR_INVALID,
	output logic CHARGE_CURRENT_CLEAR,
	output logic [11:0] MAX_CHARGE_VOLTAGE_CODE,
	output logic [5:0] MIN_SYSTEM_VOLTAGE_CODE
);
	typedef enum {ST_LOAD, ST_RUN} cvl_state_type;

	logic [1:0] strap_meta;
	logic [1:0] strap_sync;
	logic [1:0] cells;
	logic [1:0] next_cells;
	cvl_state_type state;
	cvl_state_type next_state;
	cvl_pkg::cvl_setting_type setting;
	cvl_pkg::cvl_setting_type next_setting;
	cvl_pkg::cvl_setting_type defaults;
	cvl_pkg::cvl_write_type wr;
	logic next_invalid;
	logic next_clear;
	logic [15:0] next_rd_data;
	logic [11:0] wr_chg;
	logic [5:0] wr_sys;
	logic [1:0] default_cells;

	cvl_defaults u_defaults (
		.cells(default_cells),
		.value(defaults)
	);

	// Load takes the live strap; later zero writes use the count caught at load
	assign default_cells = (state == ST_LOAD) ? strap_sync : cells;

	assign wr = '{valid: WR_VALID, offset: WR_OFFSET, data: WR_DATA};
	assign wr_chg = wr.data[cvl_pkg::CHG_CODE_MSB:cvl_pkg::CHG_CODE_LSB]; // R1 R2 R4
	assign wr_sys = wr.data[cvl_pkg::SYS_CODE_MSB:cvl_pkg::SYS_CODE_LSB]; // R5 R9 R4

	// No reset: strap is tracked while reset is held, settled for the load edge
	always_ff @(posedge CLK) begin
		strap_meta <= CELL_COUNT_STRAP_PIN;
		strap_sync <= strap_meta;
	end

	always_comb begin
		next_state = ST_RUN;
		next_setting = setting;
		next_cells = cells;
		next_invalid = 1'b0;
		next_clear = 1'b0;
		unique case (state)
			ST_LOAD: begin
				// Strap caught after release, once the synchroniser has settled
				next_cells = strap_sync;
				next_setting = defaults; // R8 R12
			end
			ST_RUN: begin
				if (wr.valid && wr.offset == cvl_pkg::MAX_CHARGE_VOLTAGE_OFFSET) begin
					if ((wr.data & cvl_pkg::CHG_RESERVED_HIGH_MASK) != 16'h0000) begin
						next_invalid = 1'b1; // R3
					end else if (wr_chg == 12'h000) begin
						next_setting.chg_code = defaults.chg_code; // R13
						next_clear = 1'b1; // R13
					end else if (wr_chg >= cvl_pkg::CHG_CODE_MIN
							&& wr_chg <= cvl_pkg::CHG_CODE_MAX) begin
						next_setting.chg_code = wr_chg; // R11
					end
				end
				if (wr.valid && wr.offset == cvl_pkg::MIN_SYSTEM_VOLTAGE_OFFSET) begin
					if ((wr.data & cvl_pkg::SYS_RESERVED_HIGH_MASK) != 16'h0000) begin
						next_invalid = 1'b1; // R3
					end else if (wr_sys >= cvl_pkg::SYS_CODE_MIN
							&& wr_sys <= cvl_pkg::SYS_CODE_MAX) begin
						next_setting.sys_code = wr_sys; // R6 R7
					end
				end
			end
		endcase
	end

	// Reads return the held code with reserved bits zero
	always_comb begin
		next_rd_data = 16'h0000;
		if (RD_OFFSET == cvl_pkg::MAX_CHARGE_VOLTAGE_OFFSET) begin
			next_rd_data[cvl_pkg::CHG_CODE_MSB:cvl_pkg::CHG_CODE_LSB] = next_setting.chg_code; // R15
		end else if (RD_OFFSET == cvl_pkg::MIN_SYSTEM_VOLTAGE_OFFSET) begin
			next_rd_data[cvl_pkg::SYS_CODE_MSB:cvl_pkg::SYS_CODE_LSB] = next_setting.sys_code; // R10 R15
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state <= ST_LOAD;
			cells <= 2'h0;
			setting <= '{chg_code: cvl_pkg::CHG_CODE_RESET, sys_code: cvl_pkg::SYS_CODE_RESET};
			WR_INVALID <= 1'b0;
			CHARGE_CURRENT_CLEAR <= 1'b0;
			RD_DATA <= 16'h0000;
		end else begin
			state <= next_state;
			cells <= next_cells;
			setting <= next_setting;
			WR_INVALID <= next_invalid;
			CHARGE_CURRENT_CLEAR <= next_clear;
			RD_DATA <= next_rd_data;
		end
	end

	assign MAX_CHARGE_VOLTAGE_CODE = setting.chg_code;
	assign MIN_SYSTEM_VOLTAGE_CODE = setting.sys_code;
endmodule : cvl_registers

// >>> hw/cvl_pkg.sv
// Package for the charge voltage limit register bank.
// Assumes an I2C protocol engine that hands over whole 16-bit register writes.
package cvl_pkg;
	localparam logic [7:0] MAX_CHARGE_VOLTAGE_OFFSET = 8'h04;
	localparam logic [7:0] MIN_SYSTEM_VOLTAGE_OFFSET = 8'h0c;
	// Charge voltage code: 12 bits at bits 14:3, 8 mV per LSB
	localparam int CHG_CODE_LSB = 3;
	localparam int CHG_CODE_MSB = 14;
	localparam int CHG_LSB_MV = 8;
	localparam int CHG_MIN_MV = 1024;
	localparam int CHG_MAX_MV = 19200;
	localparam logic [11:0] CHG_CODE_MIN = 12'(CHG_MIN_MV / CHG_LSB_MV);
	localparam logic [11:0] CHG_CODE_MAX = 12'(CHG_MAX_MV / CHG_LSB_MV);
	localparam logic [15:0] CHG_RESERVED_HIGH_MASK = 16'h8000;
	// Minimum system voltage code: 6 bits at bits 13:8, 256 mV per LSB
	localparam int SYS_CODE_LSB = 8;
	localparam int SYS_CODE_MSB = 13;
	localparam int SYS_LSB_MV = 256;
	localparam int SYS_MIN_MV = 1024;
	localparam int SYS_MAX_MV = 16128;
	localparam logic [5:0] SYS_CODE_MIN = 6'(SYS_MIN_MV / SYS_LSB_MV);
	localparam logic [5:0] SYS_CODE_MAX = 6'(SYS_MAX_MV / SYS_LSB_MV);
	localparam logic [15:0] SYS_RESERVED_HIGH_MASK = 16'hc000;
	// Defaults per cell count, index 0 = one cell
	localparam int CHG_MV_PER_CELL = 4200;
	localparam int SYS_DEFAULT_MV_1S = 3584;
	localparam int SYS_DEFAULT_MV_2S = 6144;
	localparam int SYS_DEFAULT_MV_3S = 9216;
	localparam int SYS_DEFAULT_MV_4S = 12288;
	localparam logic [11:0] CHG_CODE_RESET = 12'(CHG_MV_PER_CELL / CHG_LSB_MV);
	localparam logic [5:0] SYS_CODE_RESET = 6'(SYS_DEFAULT_MV_1S / SYS_LSB_MV);

	typedef struct packed {
		logic valid;
		logic [7:0] offset;
		logic [15:0] data;
	} cvl_write_type;

	typedef struct packed {
		logic [11:0] chg_code;
		logic [5:0] sys_code;
	} cvl_setting_type;
endpackage : cvl_pkg

// >>> hw/cvl_defaults.sv
// Cell-count default table for the setting registers.
// Assumes a synchronised two-bit cell count, 0 = one cell.
`timescale 1ns/1ps
module cvl_defaults (
	input wire logic [1:0] cells,
	output cvl_pkg::cvl_setting_type value
);
	always_comb begin
		value.chg_code = 12'((int'(cells) + 1) * cvl_pkg::CHG_MV_PER_CELL / cvl_pkg::CHG_LSB_MV); // R12
		unique case (cells) // R8
			2'h0: value.sys_code = 6'(cvl_pkg::SYS_DEFAULT_MV_1S / cvl_pkg::SYS_LSB_MV);
			2'h1: value.sys_code = 6'(cvl_pkg::SYS_DEFAULT_MV_2S / cvl_pkg::SYS_LSB_MV);
			2'h2: value.sys_code = 6'(cvl_pkg::SYS_DEFAULT_MV_3S / cvl_pkg::SYS_LSB_MV);
			2'h3: value.sys_code = 6'(cvl_pkg::SYS_DEFAULT_MV_4S / cvl_pkg::SYS_LSB_MV);
		endcase
	end
endmodule : cvl_defaults

// >>> bench/cvl_monitor.sv
// Port assertions for the voltage setting registers.
// Bound into cvl_registers below; sees its ports only.
`timescale 1ns/1ps
module cvl_monitor (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [1:0] CELL_COUNT_STRAP_PIN,
	input wire logic WR_VALID,
	input wire logic WR_INVALID,
	input wire logic CHARGE_CURRENT_CLEAR,
	input wire logic [7:0] WR_OFFSET,
	input wire logic [7:0] RD_OFFSET,
	input wire logic [15:0] WR_DATA,
	input wire logic [15:0] RD_DATA,
	input wire logic [11:0] MAX_CHARGE_VOLTAGE_CODE,
	input wire logic [5:0] MIN_SYSTEM_VOLTAGE_CODE
);
	logic live;
	wire [11:0] mc = MAX_CHARGE_VOLTAGE_CODE;
	wire [5:0] ms = MIN_SYSTEM_VOLTAGE_CODE;
	wire [11:0] c = WR_DATA[14:3];
	wire [5:0] s = WR_DATA[13:8];
	wire wc = live && WR_VALID && WR_OFFSET == 8'h04;
	wire ws = live && WR_VALID && WR_OFFSET == 8'h0c;
	wire bad = wc && WR_DATA[15] || ws && |WR_DATA[15:14];
	wire ok = c >= 12'h80 && c <= 12'h960;
	wire [11:0] dc = 12'h20d * ({10'h0, CELL_COUNT_STRAP_PIN} + 12'h1);
	// Writes on the load edge after reset are not taken
	always_ff @(posedge CLK) live <= RESETN;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	property p_bad; bad |=> WR_INVALID && $stable(mc) && $stable(ms); endproperty
	a_bad: assert property (p_bad) else $error("reserved write kept");
	property p_chg; wc && !bad && ok |=> mc == $past(c); endproperty
	a_chg: assert property (p_chg) else $error("charge not stored");
	property p_chx; wc && !bad && !ok && c != 12'h0 |=> $stable(mc); endproperty
	a_chx: assert property (p_chx) else $error("charge range");
	property p_sys; ws && !bad && s > 6'h3 |=> ms == $past(s); endproperty
	a_sys: assert property (p_sys) else $error("system not stored");
	property p_syx; ws && !bad && s < 6'h4 |=> $stable(ms); endproperty
	a_syx: assert property (p_syx) else $error("system range");
	property p_clr; wc && WR_DATA[15:3] == 13'h0 |=> CHARGE_CURRENT_CLEAR && mc == dc; endproperty
	a_clr: assert property (p_clr) else $error("zero write");
	property p_rd; RD_OFFSET == 8'h0c |=> RD_DATA == {2'h0, ms, 8'h0}; endproperty
	a_rd: assert property (p_rd) else $error("system readback");
	property p_def; $rose(RESETN) |=> mc == dc; endproperty
	a_def: assert property (p_def) else $error("charge default");
	c_clr: cover property (CHARGE_CURRENT_CLEAR);
	c_bad: cover property (WR_INVALID);
	c_sys: cover property (ws && !bad && s > 6'h3);
endmodule : cvl_monitor
bind cvl_registers cvl_monitor mon (
	.CLK(CLK),
	.RESETN(RESETN),
	.CELL_COUNT_STRAP_PIN(CELL_COUNT_STRAP_PIN),
	.WR_VALID(WR_VALID),
	.WR_INVALID(WR_INVALID),
	.CHARGE_CURRENT_CLEAR(CHARGE_CURRENT_CLEAR),
	.WR_OFFSET(WR_OFFSET),
	.RD_OFFSET(RD_OFFSET),
	.WR_DATA(WR_DATA),
	.RD_DATA(RD_DATA),
	.MAX_CHARGE_VOLTAGE_CODE(MAX_CHARGE_VOLTAGE_CODE),
	.MIN_SYSTEM_VOLTAGE_CODE(MIN_SYSTEM_VOLTAGE_CODE)
);

// >>> bench/cvl_host.sv
// Host model handing whole 16-bit register writes to the bank.
// Caller enters the write task at a falling clock edge.
`timescale 1ns/1ps
module cvl_host (
	input wire logic clk,
	output cvl_pkg::cvl_write_type wr
);
	initial wr = '0;
	// Both bytes go out together in one 16-bit write, valid for one clock
	task automatic write(input logic [7:0] o, input logic [15:0] d);
		wr <= '{1'b1, o, d};
		@(negedge clk);
		wr <= '{1'b0, ~o, ~d};
	endtask : write
endmodule : cvl_host

// >>> bench/testbench.sv
// Random and corner-case bench for the voltage setting registers.
// Writes go through cvl_host; the monitor is bound into the design.
`timescale 1ns/1ps
module testbench;
	logic CLK = 1'b0, RESETN = 1'b0, WR_INVALID, CHARGE_CURRENT_CLEAR, inv, clr;
	logic [1:0] CELL_COUNT_STRAP_PIN = 2'h0;
	logic [7:0] RD_OFFSET = 8'h0;
	logic [15:0] RD_DATA;
	logic [11:0] MAX_CHARGE_VOLTAGE_CODE, mc;
	logic [5:0] MIN_SYSTEM_VOLTAGE_CODE, ms;
	logic [31:0] r;
	int fails = 0, n_compared = 0, seed = 89;
	cvl_pkg::cvl_write_type w;
	wire [11:0] dc = 12'h20d * ({10'h0, CELL_COUNT_STRAP_PIN} + 12'h1);
	logic [5:0] sd [4] = '{6'he, 6'h18, 6'h24, 6'h30};
	logic [23:0] cor [12] = '{24'h040400, 24'h040000, 24'h0403ff, 24'h044b00, 24'h044b08,
		24'h048400, 24'h0c0300, 24'h0c0400, 24'h0c3fff, 24'h0c4000, 24'h0c0000, 24'h08ffff};
	cvl_host host (.clk(CLK), .wr(w));
	cvl_registers uut (
		.CLK(CLK),
		.RESETN(RESETN),
		.CELL_COUNT_STRAP_PIN(CELL_COUNT_STRAP_PIN),
		.WR_VALID(w.valid),
		.WR_OFFSET(w.offset),
		.WR_DATA(w.data),
		.RD_OFFSET(RD_OFFSET),
		.RD_DATA(RD_DATA),
		.WR_INVALID(WR_INVALID),
		.CHARGE_CURRENT_CLEAR(CHARGE_CURRENT_CLEAR),
		.MAX_CHARGE_VOLTAGE_CODE(MAX_CHARGE_VOLTAGE_CODE),
		.MIN_SYSTEM_VOLTAGE_CODE(MIN_SYSTEM_VOLTAGE_CODE)
	);
	// Expected read image: code in its field, reserved bits zero
	function automatic logic [15:0] read_image(input logic [7:0] o, input logic [11:0] c,
		input logic [5:0] s);
		if (o == 8'h04) return {1'b0, c, 3'h0};
		if (o == 8'h0c) return {2'h0, s, 8'h0};
		return 16'h0000;
	endfunction : read_image
	initial forever #2.5 CLK = ~CLK;
	task automatic chk(input logic [35:0] s, e);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask : chk
	task automatic step(input logic [7:0] o, input logic [15:0] v);
		inv = o == 8'h04 && v[15] || o == 8'h0c && |v[15:14];
		clr = o == 8'h04 && v[15:3] == 13'h0;
		if (clr) mc = dc;
		if (o == 8'h04 && !inv && v[14:3] >= 12'h80 && v[14:3] <= 12'h960) mc = v[14:3];
		if (o == 8'h0c && !inv && v[13:8] > 6'h3) ms = v[13:8];
		@(negedge CLK);
		RD_OFFSET <= o;
		host.write(o, v);
		chk({MAX_CHARGE_VOLTAGE_CODE, MIN_SYSTEM_VOLTAGE_CODE, WR_INVALID, CHARGE_CURRENT_CLEAR,
			RD_DATA}, {mc, ms, inv, clr, read_image(o, mc, ms)});
	endtask : step
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	initial begin
		for (int n = 0; n < 4; n++) begin
			RESETN <= 1'b0;
			CELL_COUNT_STRAP_PIN <= n[1:0];
			repeat (4) @(negedge CLK);
			RESETN <= 1'b1;
			mc = dc;
			ms = sd[n];
			step(8'h08, 16'h1234);
		end
		$display("cell default test done");
		foreach (cor[k]) step(cor[k][23:16], cor[k][15:0]);
		$display("corner test done");
		repeat (80) begin
			r = $random(seed);
			step(r[0] ? 8'h04 : 8'h0c, {r[1] & r[2], r[30:16]});
		end
		$display("random test done");
		report_and_stop();
	end
endmodule : testbench
